// [hw/drive_error_pkg.sv]
// Constants and carriers for the drive error flag bank, low byte
package drive_error_pkg;

  // Register select codes on the control bus
  localparam logic [4:0] REG_CONTROL      = 5'h00;
  localparam logic [4:0] REG_ERROR_ONE    = 5'h01;
  localparam logic [4:0] REG_MAINT        = 5'h03;
  localparam logic [4:0] REG_SUMMARY      = 5'h04;
  localparam logic [4:0] REG_SECTOR_TRACK = 5'h05;
  localparam logic [4:0] REG_OFFSET       = 5'h09;
  localparam logic [4:0] REG_CYLINDER     = 5'h0A;

  // One bit per select code that names an existing drive register
  localparam logic [31:0] REG_EXIST_MASK = 32'h0000_FFFF;

  // One bit per implemented function code (control bits 5:1)
  localparam logic [31:0] FUNC_IMPL_MASK = 32'h0FFF_FFFF;
  localparam int FUNC_LSB = 1;
  localparam int FUNC_MSB = 5;

  // Error flag positions in the low byte
  localparam int CMP_ERR_BIT  = 7;
  localparam int ECC_BIT      = 6;
  localparam int WCLK_BIT     = 5;
  localparam int FMT_BIT      = 4;
  localparam int BUS_CHK_BIT  = 3;
  localparam int REFUSED_BIT  = 2;
  localparam int BAD_SEL_BIT  = 1;
  localparam int BAD_FUNC_BIT = 0;
  // Header CRC flag sits at bit 8 of the register
  localparam int CRC_ERR_BIT  = 8;
  // Format flag position in the offset register
  localparam int OFFSET_FORMAT_BIT = 12;

  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  BUS_CHK_MASK  = 8'h08;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;

  // Control bus as seen at the drive pins
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [4:0]  sel;
    logic [15:0] data;
    logic        parity;
  } ctl_bus_s;

  // Operation status from the drive sequencer
  typedef struct packed {
    logic busy;
    logic write_cmd;
    logic read_hdr_data;
  } op_s;

  // Result of one header comparison
  typedef struct packed {
    logic valid;
    logic addr_match;
    logic crc_bad;
    logic format_flag;
  } header_s;

  // Accepted write passed on to the other drive registers
  typedef struct packed {
    logic        strobe;
    logic [4:0]  sel;
    logic [15:0] data;
  } reg_write_s;

  // Whole state of the flag bank
  typedef struct packed {
    ctl_bus_s    s1;
    ctl_bus_s    s2;
    ctl_bus_s    s3;
    logic [7:0]  flags;
    logic        crc_err;
    logic        hdr_seen;
    logic        xfer_en;
    logic        abort;
    logic        alert;
    logic [15:0] rdata;
    reg_write_s  wr;
  } state_s;

endpackage

// [hw/drive_error_flags_low.sv]
// Drive error register low byte: flag set, clear and write gating
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - On sector match, header address mismatch sets the header compare flag.
// - Address match with header CRC error clears compare flag, sets CRC flag.
// - Compare flag set on ordinary read/write blocks the data transfer.
// - Read-header-and-data still transfers the sector, flags kept.
// - Ordinary read/write transfer proceeds only when both header flags are clear.
// - Uncorrectable ECC conclusion sets the ECC flag.
// - Missing write clock during write sets its flag and aborts.
// - Header format flag unequal to offset bit 12 sets format flag.
// - Format mismatch on a write command aborts at once.
// - Control bus even parity on a write, or data bus parity error, sets parity flag.
// - Parity flag clears on drive clear, initialize or zero write.
// - Other flags clear on init, drive clear, controller clear, zero write.
// - Write during operation to a writable register but maintenance or attention summary is refused.
// - Idle: listed registers writable; the rest are read-only.
// - During operation maintenance and attention summary stay writable.
// - A refused write never aborts the running command.
// - Nonexistent register select sets the illegal register flag.
// - Writes to read-only registers are dropped without any flag.
// - Unimplemented function code loaded into control sets illegal function.
// - Any error flag set raises the attention line.
module drive_error_flags_low
  import drive_error_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire ctl_bus_s   i_ctl_bus,
  input  wire op_s        i_op,
  input  wire header_s    i_header,
  input  wire logic [15:0] i_offset_reg,
  input  wire logic       i_ecc_hard,
  input  wire logic       i_write_clock_missing,
  input  wire logic       i_data_bus_parity_error,
  input  wire logic       i_bus_init,
  input  wire logic       i_drive_clear,
  input  wire logic       i_ctrl_clear,
  input  wire logic [7:0] i_err_high,
  output logic [7:0]      o_flags,
  output logic            o_header_crc_error,
  output logic            o_xfer_enable,
  output logic            o_abort,
  output logic            o_attention_line,
  output logic [15:0]     o_rdata,
  output reg_write_s      o_reg_write
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic reg_exists(input logic [4:0] sel);
    reg_exists = REG_EXIST_MASK[sel];
  endfunction

  function automatic logic reg_writable(input logic [4:0] sel);
    reg_writable = (sel == REG_CONTROL) || (sel == REG_ERROR_ONE) ||
                   (sel == REG_MAINT) || (sel == REG_SUMMARY) ||
                   (sel == REG_SECTOR_TRACK) || (sel == REG_OFFSET) ||
                   (sel == REG_CYLINDER);
  endfunction

  function automatic logic func_ok(input logic [15:0] data);
    func_ok = FUNC_IMPL_MASK[data[FUNC_MSB:FUNC_LSB]];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops, assert stays asynchronous

  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Access decode on the synchronised bus (stage two and three only)

  state_s      st;
  state_s      next_st;
  logic        acc;
  logic        wr_acc;
  logic [4:0]  sel;
  logic        exists;
  logic        allowed;
  logic        err_write;
  logic        hdr_ev;
  logic        crc_swap;
  logic        clr_all;
  logic        clr_chk;
  logic [7:0]  set_v;

  assign acc     = st.s2.strobe && !st.s3.strobe;
  assign wr_acc  = acc && st.s2.write;
  assign sel     = st.s2.sel;
  assign exists  = reg_exists(sel);
  // Maintenance and summary writes bypass the busy gate
  assign allowed = !i_op.busy || (sel == REG_MAINT) ||
                   (sel == REG_SUMMARY);
  assign err_write = wr_acc && allowed && (sel == REG_ERROR_ONE);
  assign hdr_ev    = i_header.valid && i_op.busy;
  // Address good but CRC bad moves the blame to the CRC flag
  assign crc_swap  = hdr_ev && i_header.addr_match &&
                     i_header.crc_bad;
  // Controller clear leaves the parity flag alone
  assign clr_all = i_bus_init || i_drive_clear || i_ctrl_clear;
  assign clr_chk = i_bus_init || i_drive_clear;

  ////////////////////////////////////////////////////////////////////////
  // Flag set terms, one per event

  always_comb begin
    set_v               = FLAGS_RESET;
    set_v[CMP_ERR_BIT]  = hdr_ev && !i_header.addr_match;
    set_v[ECC_BIT]      = i_ecc_hard;
    set_v[WCLK_BIT]     = i_write_clock_missing && i_op.busy &&
                          i_op.write_cmd;
    set_v[FMT_BIT]      = hdr_ev && (i_header.format_flag !=
                          i_offset_reg[OFFSET_FORMAT_BIT]);
    set_v[BUS_CHK_BIT]  = i_data_bus_parity_error ||
                          (wr_acc && !(^{st.s2.data, st.s2.parity}));
    // Read-only targets stay silent even while busy
    set_v[REFUSED_BIT]  = wr_acc && exists && reg_writable(sel) &&
                          !allowed;
    set_v[BAD_SEL_BIT]  = acc && !exists;
    set_v[BAD_FUNC_BIT] = wr_acc && allowed && (sel == REG_CONTROL) &&
                          !func_ok(st.s2.data);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state; sets are OR-ed last so an event beats a same-cycle clear

  always_comb begin
    next_st = st;
    next_st.s1 = i_ctl_bus;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.wr.strobe = 1'b0;

    // Software write loads the byte; zeros clear the flags
    if (err_write) begin
      next_st.flags   = st.s2.data[7:0];
      next_st.crc_err = st.s2.data[CRC_ERR_BIT];
    end
    if (clr_all) begin
      next_st.flags   = next_st.flags &
                        (clr_chk ? FLAGS_RESET : BUS_CHK_MASK);
      next_st.crc_err = 1'b0;
    end
    if (crc_swap) begin
      next_st.flags[CMP_ERR_BIT] = 1'b0;
    end
    // Nothing else lowers a flag once raised
    next_st.flags   = next_st.flags | set_v;
    next_st.crc_err = next_st.crc_err | crc_swap;

    // Header result is remembered for the rest of the operation
    if (!i_op.busy) begin
      next_st.hdr_seen = 1'b0;
    end else if (hdr_ev) begin
      next_st.hdr_seen = 1'b1;
    end
    next_st.xfer_en = next_st.hdr_seen &&
                      (i_op.read_hdr_data ||
                       (!next_st.flags[CMP_ERR_BIT] &&
                        !next_st.crc_err));

    // Refused writes do not feed the abort term
    next_st.abort = set_v[WCLK_BIT] ||
                    (set_v[FMT_BIT] && i_op.write_cmd);

    next_st.alert = (|next_st.flags) || next_st.crc_err ||
                    (|i_err_high);

    // Accepted writes to the other registers are passed on
    if (wr_acc && exists && allowed && reg_writable(sel) &&
        (sel != REG_ERROR_ONE)) begin
      next_st.wr.strobe = 1'b1;
      next_st.wr.sel    = sel;
      next_st.wr.data   = st.s2.data;
    end

    // Read data holds until the next read
    if (acc && !st.s2.write) begin
      next_st.rdata = (sel == REG_ERROR_ONE) ?
                      {i_err_high[7:1], st.crc_err, st.flags} : RDATA_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags            = st.flags;
  assign o_header_crc_error = st.crc_err;
  assign o_xfer_enable      = st.xfer_en;
  assign o_abort            = st.abort;
  assign o_attention_line   = st.alert;
  assign o_rdata            = st.rdata;
  assign o_reg_write        = st.wr;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_cmp_mismatch: assert property (
    hdr_ev && !i_header.addr_match |=> o_flags[CMP_ERR_BIT])
    else $error("header mismatch did not set compare flag");

  a_crc_swap: assert property (
    crc_swap && !clr_all |=> !o_flags[CMP_ERR_BIT] && o_header_crc_error)
    else $error("header CRC error did not replace compare flag");

  // Enable was formed with the previous cycle's command kind
  a_xfer_block: assert property (
    o_xfer_enable && !$past(i_op.read_hdr_data) |->
    !o_flags[CMP_ERR_BIT] && !o_header_crc_error)
    else $error("transfer enabled despite header error");

  a_xfer_go: assert property (
    hdr_ev && i_header.addr_match && !i_header.crc_bad && !err_write &&
    !o_flags[CMP_ERR_BIT] && !o_header_crc_error |=> o_xfer_enable)
    else $error("clean header did not enable transfer");

  a_rhd_xfer: assert property (
    hdr_ev && i_op.read_hdr_data |=> o_xfer_enable)
    else $error("read header and data did not transfer");

  a_ecc_hard: assert property (
    i_ecc_hard |=> o_flags[ECC_BIT])
    else $error("ECC flag not set");

  a_wclk_abort: assert property (
    set_v[WCLK_BIT] |=> o_abort && o_flags[WCLK_BIT] ##1 !o_abort)
    else $error("write clock loss did not abort once");

  a_fmt_flag: assert property (
    hdr_ev && (i_header.format_flag != i_offset_reg[OFFSET_FORMAT_BIT])
    |=> o_flags[FMT_BIT])
    else $error("format mismatch did not set format flag");

  a_fmt_abort: assert property (
    set_v[FMT_BIT] && i_op.write_cmd |=> o_abort)
    else $error("format mismatch on write did not abort");

  a_parity: assert property (
    wr_acc && !(^{st.s2.data, st.s2.parity}) |=> o_flags[BUS_CHK_BIT])
    else $error("bus parity error not flagged");

  a_chk_keep: assert property (
    o_flags[BUS_CHK_BIT] && i_ctrl_clear && !clr_chk && !err_write
    |=> o_flags[BUS_CHK_BIT])
    else $error("controller clear dropped parity flag");

  a_clear_all: assert property (
    clr_all && set_v == FLAGS_RESET && !crc_swap
    |=> (o_flags & ~BUS_CHK_MASK) == FLAGS_RESET && !o_header_crc_error)
    else $error("clear left an error flag set");

  a_refused: assert property (
    wr_acc && i_op.busy && exists && reg_writable(sel) &&
    sel != REG_MAINT && sel != REG_SUMMARY
    |=> o_flags[REFUSED_BIT] && !o_reg_write.strobe && !o_abort)
    else $error("busy write not refused correctly");

  a_busy_open: assert property (
    wr_acc && i_op.busy && (sel == REG_MAINT || sel == REG_SUMMARY)
    |=> o_reg_write.strobe && o_reg_write.sel == $past(sel))
    else $error("maintenance or summary write not passed on");

  a_bad_sel: assert property (
    acc && !exists |=> o_flags[BAD_SEL_BIT])
    else $error("illegal register not flagged");

  a_bad_func: assert property (
    wr_acc && !i_op.busy && sel == REG_CONTROL &&
    !FUNC_IMPL_MASK[st.s2.data[FUNC_MSB:FUNC_LSB]]
    |=> o_flags[BAD_FUNC_BIT])
    else $error("unimplemented function code not flagged");

  a_sticky: assert property (
    !clr_all && !err_write && !crc_swap
    |=> (o_flags & $past(o_flags)) == $past(o_flags))
    else $error("flag dropped without clearing source");

  a_alert_line: assert property (
    (|o_flags) |-> o_attention_line)
    else $error("attention not raised for error flag");

  c_cmp_err: cover property (hdr_ev && !i_header.addr_match);
  c_rhd: cover property (o_xfer_enable && o_flags[CMP_ERR_BIT]);
  c_refuse: cover property (set_v[REFUSED_BIT]);
  c_abort: cover property (o_abort);
  c_crc_swap: cover property (crc_swap);

endmodule

// [tb/bus_controller_model.sv]
// Controller model driving word transfers on the drive control bus
`timescale 1ns/1ps

module bus_controller_model
  import drive_error_pkg::*;
(
  input  wire logic i_clk,
  output ctl_bus_s  o_bus
);
  initial o_bus = '0;
  // Strobe stands 3 cycles high, 3 low: above the 2-cycle minimum
  task automatic access(input logic w, input logic [4:0] s,
                        input logic [15:0] d, input logic bad);
    @(negedge i_clk);
    o_bus.write  = w;
    o_bus.sel    = s;
    o_bus.data   = d;
    o_bus.parity = ~^d ^ bad;
    // Word settles a cycle ahead of the strobe, so it is whole when taken
    @(negedge i_clk);
    o_bus.strobe = 1'b1;
    repeat (3) @(negedge i_clk);
    // Released lines must not keep showing the last word
    o_bus.strobe = 1'b0;
    o_bus.data   = ~o_bus.data;
    o_bus.parity = ~o_bus.parity;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

// [tb/drive_error_flags_low_tb_top.sv]
// Self-checking bench for the drive error flag bank
`timescale 1ns/1ps

module drive_error_flags_low_tb_top
  import drive_error_pkg::*;
;
  logic        i_clk = 0;
  logic        i_resetn = 0;
  ctl_bus_s    bus;
  op_s         op = '0;
  header_s     hdr = '0;
  logic        ecc = 0, wclk = 0, dpar = 0;
  logic        binit = 0, dclr = 0, cclr = 0;
  logic [7:0]  ehi = 0, flags;
  logic        crc, xfer, abrt, alert;
  logic [15:0] rdata, d, ofs = 16'h1000;
  reg_write_s  rw, last;
  int          n_mismatch = 0, checked = 0, cyc = 0, fwd = 0, ab = 0, f0;

  always #10 i_clk = ~i_clk;

  bus_controller_model bus_controller_model_inst (
    .i_clk(i_clk), .o_bus(bus));

  drive_error_flags_low drive_error_flags_low_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ctl_bus(bus), .i_op(op),
    .i_header(hdr), .i_offset_reg(ofs), .i_ecc_hard(ecc),
    .i_write_clock_missing(wclk), .i_data_bus_parity_error(dpar),
    .i_bus_init(binit), .i_drive_clear(dclr), .i_ctrl_clear(cclr),
    .i_err_high(ehi), .o_flags(flags), .o_header_crc_error(crc),
    .o_xfer_enable(xfer), .o_abort(abrt), .o_attention_line(alert),
    .o_rdata(rdata), .o_reg_write(rw));

  task automatic conclude();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watch pulses at the falling edge, where registered outputs settle
  always @(negedge i_clk) begin
    cyc++;
    if (rw.strobe === 1'b1) begin
      fwd++;
      last = rw;
    end
    if (abrt === 1'b1) ab++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1;
    @(negedge i_clk) s = 0;
    @(negedge i_clk);
  endtask

  // Busy drops between headers so each compare counts afresh
  task automatic head(input logic m, c, f);
    @(negedge i_clk) op.busy = 0;
    @(negedge i_clk) op.busy = 1;
    hdr = '{1'b1, m, c, f};
    @(negedge i_clk) hdr.valid = 0;
    @(negedge i_clk);
  endtask

  function automatic logic wable(input logic [4:0] s);
    return s inside {REG_CONTROL, REG_ERROR_ONE, REG_MAINT, REG_SUMMARY,
                     REG_SECTOR_TRACK, REG_OFFSET, REG_CYLINDER};
  endfunction

  function automatic logic open_busy(input logic [4:0] s);
    return s inside {REG_MAINT, REG_SUMMARY};
  endfunction

  function automatic logic [7:0] exp_fl(input logic [4:0] s,
                                        input logic b);
    if (!REG_EXIST_MASK[s]) return 8'h02;
    if (b && wable(s) && !open_busy(s)) return 8'h04;
    return 8'h00;
  endfunction

  function automatic logic exp_fwd(input logic [4:0] s, input logic b);
    return wable(s) && s != REG_ERROR_ONE && (!b || open_busy(s));
  endfunction

  initial begin
    void'($urandom(32'hB27E8AA3));
    ofs = 16'($urandom);
    repeat (2) @(negedge i_clk);
    i_resetn = 1;
    repeat (3) @(negedge i_clk);
    chk(flags, FLAGS_RESET);
    chk(rdata, RDATA_RESET);
    // Every select code, idle and busy, as writes
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 32; s++) begin
        pulse(binit);
        op.busy = b[0];
        d = s == 1 ? 16'h0000 : 16'($urandom) & 16'hFFC0;
        f0 = fwd;
        bus_controller_model_inst.access(1, 5'(s), d, 0);
        chk(flags, exp_fl(5'(s), b[0]));
        chk(16'(fwd - f0), 16'(exp_fwd(5'(s), b[0])));
        if (exp_fwd(5'(s), b[0])) begin
          chk(last.data, d);
          chk(16'(last.sel), 16'(s));
        end
        op.busy = 0;
      end
    end
    chk(16'(ab), 16'h0000);
    pulse(binit);
    bus_controller_model_inst.access(1, REG_CONTROL, 16'h0038, 0);
    chk(flags, 8'h01);
    pulse(binit);
    // Parity is checked on words the controller sends, so use a write
    bus_controller_model_inst.access(1, REG_OFFSET, 16'h1234, 1);
    chk(flags, 8'h08);
    head(0, 0, ofs[12]);
    chk(flags[7], 1);
    chk(xfer, 0);
    head(1, 1, ofs[12]);
    chk({crc, flags[7]}, 2'b10);
    chk(xfer, 0);
    pulse(dclr);
    head(1, 0, ofs[12]);
    chk(xfer, 1);
    op.read_hdr_data = 1;
    head(0, 0, ofs[12]);
    chk({flags[7], xfer}, 2'b11);
    op = '{1'b1, 1'b1, 1'b0};
    head(1, 0, ~ofs[12]);
    chk(flags[4], 1);
    chk(16'(ab), 16'h0001);
    pulse(wclk);
    chk(flags[5], 1);
    chk(16'(ab), 16'h0002);
    pulse(ecc);
    chk(flags[6], 1);
    pulse(dpar);
    op = '0;
    repeat (6) @(negedge i_clk);
    chk(flags, 8'hF8);
    chk(alert, 1);
    pulse(cclr);
    chk(flags, 8'h08);
    pulse(dclr);
    chk(flags, 8'h00);
    d = 16'($urandom) & 16'h01FF;
    bus_controller_model_inst.access(1, REG_ERROR_ONE, d, 0);
    chk({crc, flags}, d[8:0]);
    bus_controller_model_inst.access(0, REG_ERROR_ONE, 16'h0000, 0);
    chk(rdata, d);
    bus_controller_model_inst.access(1, REG_ERROR_ONE, 16'h0000, 0);
    chk({crc, flags, alert}, 10'h000);
    ehi = 8'h04;
    repeat (2) @(negedge i_clk);
    chk(alert, 1);
    conclude();
  end
endmodule
